// file: mcec_pkg.sv
// Package with the register map, field positions and reset values of the classifier.
package mcec_pkg;

    // Number of error-reporting banks.
    localparam int          NB          = 4;
    localparam logic [1:0]  BANK_IDX_W1 = 2'h3;

    // Register byte addresses.
    localparam logic [7:0]  ADDR_CAP    = 8'h00;
    localparam logic [7:0]  ADDR_STATE  = 8'h04;
    localparam logic [7:0]  ADDR_EXT    = 8'h08;
    localparam logic [7:0]  ADDR_CLASS  = 8'h0C;
    localparam logic [7:0]  ADDR_BANK0  = 8'h10;

    // Global capability fields.
    localparam int          CAP_RECOV   = 24;
    localparam int          CAP_LOCAL   = 27;

    // Global check state fields.
    localparam int          ST_RESTART  = 0;
    localparam int          ST_LINKED   = 1;
    localparam int          ST_PROGRESS = 2;
    localparam int          ST_SHUTDOWN = 3;

    // Global extended control fields.
    localparam int          EXT_LOCAL_ON = 0;

    // Bank status fields; bits [15:0] hold the error code.
    localparam int          BS_VALID    = 31;
    localparam int          BS_OVER     = 30;
    localparam int          BS_UNCORR   = 29;
    localparam int          BS_ARMED    = 28;
    localparam int          BS_CORRUPT  = 25;
    localparam int          BS_RKIND    = 24;
    localparam int          BS_ACTION   = 23;

    // Severity class bits, one byte per bank in the class register.
    localparam int          CLASS_W     = 8;
    localparam int          CL_CORR     = 0;
    localparam int          CL_NONEN    = 1;
    localparam int          CL_FATAL    = 2;
    localparam int          CL_NOACT    = 3;
    localparam int          CL_UCR      = 4;
    localparam int          CL_OPT      = 5;
    localparam int          CL_REQ      = 6;
    localparam int          CL_LOST     = 7;

    // Reset values.
    localparam logic [31:0] RST_BANK    = 32'h0000_0000;
    localparam logic        RST_FLAG    = 1'b0;
    localparam logic [31:0] RST_RDATA   = 32'h0000_0000;

endpackage : mcec_pkg

// file: mcec_bank_class.sv
// Severity classifier for one bank status word.
module mcec_bank_class (
    // Status word and capability
    input  wire logic [31:0] status,
    input  wire logic        recov_on,
    // Class bits
    output logic      [7:0]  cls
);

    wire logic val  = status[mcec_pkg::BS_VALID];
    wire logic uc   = status[mcec_pkg::BS_UNCORR];
    wire logic en   = status[mcec_pkg::BS_ARMED];
    wire logic context_corrupt_flag  = status[mcec_pkg::BS_CORRUPT];
    wire logic s    = status[mcec_pkg::BS_RKIND];
    wire logic ar   = status[mcec_pkg::BS_ACTION];
    wire logic over = status[mcec_pkg::BS_OVER];

    wire logic unc_v = val & uc;
    wire logic rec_v = unc_v & recov_on;

    wire logic is_corr  = val & ~uc;
    wire logic no_rec   = unc_v & ~recov_on;
    wire logic is_noact = rec_v & ~context_corrupt_flag & ~s & ~ar;
    wire logic is_nonen = rec_v & ~en & ~is_noact;
    wire logic is_ucr   = rec_v & en & ~context_corrupt_flag;
    wire logic ctx_bad  = rec_v & en & context_corrupt_flag;

    // A recovery-kind clear with action-needed set is not a legal pair.
    wire logic illegal  = is_ucr & ~s & ar;

    assign cls[mcec_pkg::CL_CORR]  = is_corr;
    assign cls[mcec_pkg::CL_NONEN] = is_nonen;
    assign cls[mcec_pkg::CL_FATAL] = no_rec | ctx_bad | illegal;
    assign cls[mcec_pkg::CL_NOACT] = is_noact;
    assign cls[mcec_pkg::CL_UCR]   = is_ucr;
    assign cls[mcec_pkg::CL_OPT]   = is_ucr & s & ~ar;
    assign cls[mcec_pkg::CL_REQ]   = is_ucr & s & ar;
    assign cls[mcec_pkg::CL_LOST]  = val & over;

endmodule : mcec_bank_class

// file: mcec_top.sv
// Machine-check error classifier with bank status, global state and delivery.
//
// Added by the designer: the plain strobed port and the register offsets.

module mcec_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Capability straps
    input  wire logic        cap_recovery,
    input  wire logic        cap_local,
    // Error detectors
    input  wire logic        err_report,
    input  wire logic [1:0]  err_bank,
    input  wire logic [31:0] err_status,
    input  wire logic        err_restart_ok,
    input  wire logic        err_ip_linked,
    input  wire logic        err_local_ok,
    // Exception delivery and state
    output logic             check_exc_bcast,
    output logic             check_exc_local,
    output logic             check_in_progress,
    output logic             shutdown,
    output logic             fatal_pending
);

    // Byte address of a bank status register.
    function automatic logic [7:0] bank_addr(input logic [1:0] idx);
        bank_addr = mcec_pkg::ADDR_BANK0 + {4'h0, idx, 2'h0};
    endfunction : bank_addr

    // Merges a new report into a bank; an uncorrected report displaces a corrected one.
    function automatic logic [31:0] merge_status(input logic [31:0] old_st,
                                                 input logic [31:0] new_st);
        logic [31:0] res;
        res = new_st;
        res[mcec_pkg::BS_VALID] = 1'b1;
        if (old_st[mcec_pkg::BS_VALID]) begin
            if (old_st[mcec_pkg::BS_UNCORR] || !new_st[mcec_pkg::BS_UNCORR]) begin
                res = old_st;
            end
            res[mcec_pkg::BS_OVER] = 1'b1;
        end
        merge_status = res;
    endfunction : merge_status

    // Capability, global state and control flops.
    logic        cap_recov_reg;
    logic        cap_local_reg;
    logic        restart_reg;
    logic        restart_next;
    logic        linked_reg;
    logic        linked_next;
    logic        prog_reg;
    logic        prog_next;
    logic        shut_reg;
    logic        shut_next;
    logic        local_on_reg;
    logic        local_on_next;
    logic        bcast_reg;
    logic        bcast_next;
    logic        lexc_reg;
    logic        lexc_next;
    logic        fatal_reg;
    logic        fatal_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Bank storage and classes.
    logic [31:0] bank_reg   [mcec_pkg::NB];
    logic [31:0] bank_next  [mcec_pkg::NB];
    logic [7:0]  bank_cls   [mcec_pkg::NB];
    logic [mcec_pkg::NB-1:0] bank_fatal;
    logic [7:0]  inc_cls;
    logic [31:0] inc_status;

    // Register decode.
    wire logic wr_state = reg_wr && (reg_addr == mcec_pkg::ADDR_STATE);
    wire logic wr_ext   = reg_wr && (reg_addr == mcec_pkg::ADDR_EXT);

    // Incoming report classification.
    assign inc_status = err_status | (32'h0000_0001 << mcec_pkg::BS_VALID);

    mcec_bank_class u_inc_class (
        .status   (inc_status),
        .recov_on (cap_recov_reg),
        .cls      (inc_cls)
    );

    // Armed uncorrected reports raise an exception, unless of the no-action class.
    wire logic inc_raise = err_report
                         && err_status[mcec_pkg::BS_UNCORR]
                         && err_status[mcec_pkg::BS_ARMED]
                         && !inc_cls[mcec_pkg::CL_NOACT];

    // After shutdown the core takes no further exceptions.
    wire logic exc_fire  = inc_raise && !shut_reg;
    wire logic recursion = exc_fire && prog_reg;
    wire logic deliver   = exc_fire && !prog_reg;
    wire logic use_local = cap_local_reg && local_on_reg && err_local_ok;

    assign bcast_next = deliver && !use_local;
    assign lexc_next  = deliver && use_local;

    // Hardware setting wins over a software write in the same cycle.
    assign prog_next    = deliver ? 1'b1
                        : wr_state ? reg_wdata[mcec_pkg::ST_PROGRESS]
                        : prog_reg;
    assign restart_next = deliver ? err_restart_ok
                        : wr_state ? reg_wdata[mcec_pkg::ST_RESTART]
                        : restart_reg;
    assign linked_next  = deliver ? err_ip_linked
                        : wr_state ? reg_wdata[mcec_pkg::ST_LINKED]
                        : linked_reg;
    assign shut_next    = shut_reg || recursion;
    assign local_on_next = wr_ext ? reg_wdata[mcec_pkg::EXT_LOCAL_ON] : local_on_reg;
    assign fatal_next   = |bank_fatal;

    // Per-bank status update and classification.
    genvar gi;
    generate
        for (gi = 0; gi < mcec_pkg::NB; gi++) begin : g_bank
            wire logic hw_hit = err_report && (err_bank == 2'(gi));
            wire logic sw_hit = reg_wr && (reg_addr == bank_addr(2'(gi)));

            // Detector reports win over a software clear.
            assign bank_next[gi] = hw_hit ? merge_status(bank_reg[gi], err_status)
                                 : sw_hit ? reg_wdata
                                 : bank_reg[gi];

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    bank_reg[gi] <= mcec_pkg::RST_BANK;
                end else begin
                    bank_reg[gi] <= bank_next[gi];
                end
            end

            mcec_bank_class u_class (
                .status   (bank_reg[gi]),
                .recov_on (cap_recov_reg),
                .cls      (bank_cls[gi])
            );

            assign bank_fatal[gi] = bank_cls[gi][mcec_pkg::CL_FATAL];
        end
    endgenerate

    // Read data selection; unmapped addresses read as zero.
    always_comb begin
        rdata_next = mcec_pkg::RST_RDATA;
        if (reg_addr == mcec_pkg::ADDR_CAP) begin
            rdata_next[mcec_pkg::CAP_RECOV] = cap_recov_reg;
            rdata_next[mcec_pkg::CAP_LOCAL] = cap_local_reg;
            rdata_next[7:0] = 8'(mcec_pkg::NB);
        end else if (reg_addr == mcec_pkg::ADDR_STATE) begin
            rdata_next[mcec_pkg::ST_RESTART]  = restart_reg;
            rdata_next[mcec_pkg::ST_LINKED]   = linked_reg;
            rdata_next[mcec_pkg::ST_PROGRESS] = prog_reg;
            rdata_next[mcec_pkg::ST_SHUTDOWN] = shut_reg;
        end else if (reg_addr == mcec_pkg::ADDR_EXT) begin
            rdata_next[mcec_pkg::EXT_LOCAL_ON] = local_on_reg;
        end else if (reg_addr == mcec_pkg::ADDR_CLASS) begin
            rdata_next = {bank_cls[3], bank_cls[2], bank_cls[1], bank_cls[0]};
        end else begin
            for (int i = 0; i < mcec_pkg::NB; i++) begin
                if (reg_addr == bank_addr(2'(i))) begin
                    rdata_next = bank_reg[i];
                end
            end
        end
        if (!reg_rd) begin
            rdata_next = mcec_pkg::RST_RDATA;
        end
    end

    // Capability straps are followed every cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cap_recov_reg <= mcec_pkg::RST_FLAG;
            cap_local_reg <= mcec_pkg::RST_FLAG;
        end else begin
            cap_recov_reg <= cap_recovery;
            cap_local_reg <= cap_local;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            restart_reg <= mcec_pkg::RST_FLAG;
            linked_reg  <= mcec_pkg::RST_FLAG;
            prog_reg    <= mcec_pkg::RST_FLAG;
            shut_reg    <= mcec_pkg::RST_FLAG;
        end else begin
            restart_reg <= restart_next;
            linked_reg  <= linked_next;
            prog_reg    <= prog_next;
            shut_reg    <= shut_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            local_on_reg <= mcec_pkg::RST_FLAG;
            bcast_reg    <= mcec_pkg::RST_FLAG;
            lexc_reg     <= mcec_pkg::RST_FLAG;
            fatal_reg    <= mcec_pkg::RST_FLAG;
            rdata_reg    <= mcec_pkg::RST_RDATA;
        end else begin
            local_on_reg <= local_on_next;
            bcast_reg    <= bcast_next;
            lexc_reg     <= lexc_next;
            fatal_reg    <= fatal_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign reg_rdata         = rdata_reg;
    assign check_exc_bcast   = bcast_reg;
    assign check_exc_local   = lexc_reg;
    assign check_in_progress = prog_reg;
    assign shutdown          = shut_reg;
    assign fatal_pending     = fatal_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_deliver;
        deliver;
    endsequence

    sequence seq_entered;
        check_in_progress && (check_exc_bcast || check_exc_local);
    endsequence

    sequence seq_pulse_ends;
        !check_exc_bcast && !check_exc_local;
    endsequence

    chk_enter_progress: assert property (
        seq_deliver |=> seq_entered ##1 seq_pulse_ends
    ) else $error("Exception did not set check-in-progress with one pulse.");

    chk_recursion_stop: assert property (
        exc_fire && check_in_progress |=> shutdown and seq_pulse_ends
    ) else $error("Check during in-progress did not shut down.");

    chk_shutdown_quiet: assert property (
        $past(shutdown) |-> shutdown and seq_pulse_ends
    ) else $error("Exception delivered after shutdown.");

    chk_restart_load: assert property (
        deliver |=> restart_reg == $past(err_restart_ok)
    ) else $error("Restart flag not loaded on exception.");

    chk_local_route: assert property (
        deliver && cap_local_reg && local_on_reg && err_local_ok
        |=> check_exc_local && !check_exc_bcast
    ) else $error("Local delivery not taken.");

    chk_bcast_route: assert property (
        deliver && !(cap_local_reg && local_on_reg) |=> check_exc_bcast && !check_exc_local
    ) else $error("Broadcast delivery not taken.");

    chk_norecov_fatal: assert property (
        !cap_recov_reg && bank_reg[0][mcec_pkg::BS_VALID] && bank_reg[0][mcec_pkg::BS_UNCORR]
        |-> bank_cls[0][mcec_pkg::CL_FATAL] && !bank_cls[0][mcec_pkg::CL_UCR]
    ) else $error("Uncorrected error not fatal without recovery support.");

    chk_linked_cause: assert property (
        $rose(linked_reg) |-> $past(deliver && err_ip_linked) || $past(wr_state)
    ) else $error("Pointer-linked flag set without a linked exception.");

    chk_quiet_unarmed: assert property (
        err_report && !err_status[mcec_pkg::BS_ARMED] && !check_in_progress
        |=> seq_pulse_ends and !check_in_progress
    ) else $error("Non-enabled error raised an exception.");

    chk_noact_quiet: assert property (
        err_report && inc_cls[mcec_pkg::CL_NOACT] && !check_in_progress
        |=> seq_pulse_ends and !check_in_progress
    ) else $error("No-action error raised an exception.");

    chk_invalid_empty: assert property (
        !bank_reg[1][mcec_pkg::BS_VALID] |-> bank_cls[1] == 8'h00
    ) else $error("Invalid bank carries a class.");

    chk_corr_class: assert property (
        bank_reg[2][mcec_pkg::BS_VALID] && !bank_reg[2][mcec_pkg::BS_UNCORR]
        |-> bank_cls[2][mcec_pkg::CL_CORR] && !bank_cls[2][mcec_pkg::CL_FATAL]
    ) else $error("Corrected error misclassified.");

    chk_req_class: assert property (
        cap_recov_reg && bank_reg[0][31] && bank_reg[0][29:28] == 2'h3
        && bank_reg[0][25:23] == 3'h3
        |-> bank_cls[0][mcec_pkg::CL_REQ] && bank_cls[0][mcec_pkg::CL_UCR]
    ) else $error("Required-recovery error misclassified.");

    chk_opt_class: assert property (
        cap_recov_reg && bank_reg[3][mcec_pkg::BS_VALID] && bank_reg[3][mcec_pkg::BS_UNCORR]
        && bank_reg[3][mcec_pkg::BS_ARMED] && !bank_reg[3][mcec_pkg::BS_CORRUPT]
        && bank_reg[3][mcec_pkg::BS_RKIND] && !bank_reg[3][mcec_pkg::BS_ACTION]
        |-> bank_cls[3][mcec_pkg::CL_OPT] && !bank_cls[3][mcec_pkg::CL_REQ]
    ) else $error("Optional-recovery error misclassified.");

    chk_ctx_fatal: assert property (
        cap_recov_reg && bank_reg[1][mcec_pkg::BS_VALID] && bank_reg[1][mcec_pkg::BS_UNCORR]
        && bank_reg[1][mcec_pkg::BS_ARMED] && bank_reg[1][mcec_pkg::BS_CORRUPT]
        |-> bank_cls[1][mcec_pkg::CL_FATAL] && !bank_cls[1][mcec_pkg::CL_UCR]
    ) else $error("Context-corrupt error not classed fatal.");

    chk_read_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0
    ) else $error("Read data shown without a read.");

    chk_read_late: assert property (
        reg_rd && reg_addr == mcec_pkg::ADDR_STATE
        |=> reg_rdata[mcec_pkg::ST_PROGRESS] == $past(prog_reg)
        ##1 (reg_rdata == 32'h0 || $past(reg_rd))
    ) else $error("Read data not in the cycle after the read.");

endmodule : mcec_top

// file: tb_mcec_top.sv
// Self-checking testbench of the machine-check error classifier.
module tb_mcec_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        cap_recovery;
    logic        cap_local;
    logic        err_report;
    logic [1:0]  err_bank;
    logic [31:0] err_status;
    logic        err_restart_ok;
    logic        err_ip_linked;
    logic        err_local_ok;
    logic        check_exc_bcast;
    logic        check_exc_local;
    logic        check_in_progress;
    logic        shutdown;
    logic        fatal_pending;
    int          n_fail;
    int          n_tests;
    integer      seed;
    logic [31:0] bank_m [4];
    logic        cip_m;
    logic        shut_m;
    logic        loc_m;
    logic        go_m;
    logic        rs_m;
    logic        lk_m;
    logic [31:0] rd;
    logic [31:0] st;
    logic [1:0]  b;

    mcec_top dut_u (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cap_recovery(cap_recovery), .cap_local(cap_local), .err_report(err_report),
        .err_bank(err_bank), .err_status(err_status), .err_restart_ok(err_restart_ok),
        .err_ip_linked(err_ip_linked), .err_local_ok(err_local_ok),
        .check_exc_bcast(check_exc_bcast), .check_exc_local(check_exc_local),
        .check_in_progress(check_in_progress), .shutdown(shutdown),
        .fatal_pending(fatal_pending)
    );

    always #50 clk = ~clk;

    function automatic logic [7:0] cls_of(input logic [31:0] s, input logic rc);
        logic [7:0] c;
        logic       v, uc, en, cp, kd, ar, recoverable_uncorrected_class;
        v   = s[mcec_pkg::BS_VALID];
        uc  = s[mcec_pkg::BS_UNCORR];
        en  = s[mcec_pkg::BS_ARMED];
        cp  = s[mcec_pkg::BS_CORRUPT];
        kd  = s[mcec_pkg::BS_RKIND];
        ar  = s[mcec_pkg::BS_ACTION];
        recoverable_uncorrected_class = v & uc & rc & en & !cp;
        c = 8'h00;
        c[mcec_pkg::CL_CORR]  = v & !uc;
        c[mcec_pkg::CL_NONEN] = v & uc & rc & !en & (cp | kd | ar);
        c[mcec_pkg::CL_FATAL] = v & uc & (!rc | (en & cp) | (en & !cp & !kd & ar));
        c[mcec_pkg::CL_NOACT] = v & uc & rc & !cp & !kd & !ar;
        c[mcec_pkg::CL_UCR]   = recoverable_uncorrected_class;
        c[mcec_pkg::CL_OPT]   = recoverable_uncorrected_class & kd & !ar;
        c[mcec_pkg::CL_REQ]   = recoverable_uncorrected_class & kd & ar;
        c[mcec_pkg::CL_LOST]  = v & s[mcec_pkg::BS_OVER];
        return c;
    endfunction : cls_of

    // Bits whose value the rules leave open are not compared.
    function automatic logic [7:0] cls_mask(input logic [31:0] s, input logic rc);
        logic [7:0] m;
        m = 8'hFF;
        m[mcec_pkg::CL_NONEN] = rc;
        m[mcec_pkg::CL_UCR]   = s[mcec_pkg::BS_RKIND] | !s[mcec_pkg::BS_ACTION];
        return m;
    endfunction : cls_mask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rdr

    task automatic report(input logic [1:0] bk, input logic [31:0] s, input logic rs,
                          input logic lk, input logic lo);
        logic [31:0] ns;
        logic        raise;
        logic        loc;
        ns    = s | 32'h8000_0000;
        raise = ns[29] & ns[28] & (!cap_recovery | ns[25] | ns[24] | ns[23]);
        loc   = cap_local & loc_m & lo;
        go_m  = raise & !shut_m & !cip_m;
        rs_m  = rs;
        lk_m  = lk;
        @(posedge clk);
        err_report     <= 1'b1;
        err_bank       <= bk;
        err_status     <= s;
        err_restart_ok <= rs;
        err_ip_linked  <= lk;
        err_local_ok   <= lo;
        @(posedge clk);
        err_report     <= 1'b0;
        #1;
        chk1(check_exc_bcast, go_m & !loc);
        chk1(check_exc_local, go_m & loc);
        if (raise & cip_m) shut_m = 1'b1;
        if (go_m) cip_m = 1'b1;
        chk1(check_in_progress, cip_m);
        chk1(shutdown, shut_m);
        if (!bank_m[bk][31]) bank_m[bk] = ns;
        else if (!bank_m[bk][29] & ns[29]) bank_m[bk] = ns | 32'h4000_0000;
        else bank_m[bk] = bank_m[bk] | 32'h4000_0000;
    endtask : report

    task automatic check_all();
        logic [31:0] e;
        logic [31:0] m;
        e = 32'h0;
        m = 32'h0;
        for (int i = 0; i < 4; i++) begin
            rdr(mcec_pkg::ADDR_BANK0 + 8'(4 * i), rd);
            chk32(rd, bank_m[i]);
            e[8*i +: 8] = cls_of(bank_m[i], cap_recovery);
            m[8*i +: 8] = cls_mask(bank_m[i], cap_recovery);
        end
        rdr(mcec_pkg::ADDR_CLASS, rd);
        chk32(rd & m, e & m);
        chk1(fatal_pending, |(e & 32'h0404_0404));
        rdr(mcec_pkg::ADDR_STATE, rd);
        chk32(rd & {30'h3FFF_FFFF, go_m, go_m}, {28'h0, shut_m, cip_m, lk_m & go_m, rs_m & go_m});
        rdr(mcec_pkg::ADDR_EXT, rd);
        chk32(rd, {31'h0, loc_m});
    endtask : check_all

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        bank_m = '{default: 32'h0};
        cip_m  = 1'b0;
        shut_m = 1'b0;
        loc_m  = 1'b0;
        go_m   = 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial begin
        clk            = 1'b0;
        resetn         = 1'b0;
        reg_addr       = 8'h00;
        reg_wdata      = 32'h0;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        cap_recovery   = 1'b0;
        cap_local      = 1'b0;
        err_report     = 1'b0;
        err_bank       = 2'h0;
        err_status     = 32'h0;
        err_restart_ok = 1'b0;
        err_ip_linked  = 1'b0;
        err_local_ok   = 1'b0;
        n_fail         = 0;
        n_tests        = 0;
        seed           = 32'h1F97;
        do_reset();
        check_all();
        // Read-only and unmapped places must not take writes.
        wr(mcec_pkg::ADDR_CAP, 32'hFFFF_FFFF);
        wr(mcec_pkg::ADDR_CLASS, 32'hFFFF_FFFF);
        wr(8'h40, 32'hFFFF_FFFF);
        rdr(8'h40, rd);
        chk32(rd, 32'h0);
        check_all();
        for (int ph = 0; ph < 4; ph++) begin
            @(posedge clk);
            cap_recovery <= ph[0];
            cap_local    <= ph[1];
            repeat (2) @(posedge clk);
            rdr(mcec_pkg::ADDR_CAP, rd);
            chk32(rd, {4'h0, ph[1], 2'h0, ph[0], 16'h0, 8'h04});
            for (int k = 0; k < 60; k++) begin
                b = 2'($random(seed));
                if (($random(seed) & 3) != 0) begin
                    wr(mcec_pkg::ADDR_BANK0 + {4'h0, b, 2'h0}, 32'h0);
                    bank_m[b] = 32'h0;
                end
                st = $random(seed);
                if (ph[0] == 0) st[mcec_pkg::BS_CORRUPT] = 1'b1;
                report(b, st, 1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
                check_all();
                wr(mcec_pkg::ADDR_STATE, 32'h0);
                cip_m = 1'b0;
                loc_m = 1'($random(seed));
                wr(mcec_pkg::ADDR_EXT, {31'h0, loc_m});
            end
        end
        for (int k = 0; k < 7; k++) begin
            wr(mcec_pkg::ADDR_BANK0 + 8'h08, 32'h0);
            bank_m[2] = 32'h0;
            st = (k == 0) ? 32'h0000_0001 : (k == 1) ? 32'h2000_0000 :
                 (k == 2) ? 32'h3200_0000 : (k == 3) ? 32'h3000_0000 :
                 (k == 4) ? 32'h3100_0005 : (k == 5) ? 32'h3180_0006 : 32'h3080_0000;
            report(2'h2, st, 1'b1, 1'b0, 1'b0);
            check_all();
            wr(mcec_pkg::ADDR_STATE, 32'h0);
            cip_m = 1'b0;
        end
        // A check while one is in progress ends in shutdown, kept until reset.
        for (int k = 0; k < 3; k++) begin
            report(2'(k), 32'h3180_0001, 1'b1, 1'b1, 1'b0);
        end
        check_all();
        do_reset();
        chk1(shutdown, 1'b0);
        check_all();
        finish_test();
    end

endmodule : tb_mcec_top
